/* logic/file_access_register_interface.sv */
`timescale 1ns/10ps
`default_nettype none
module file_access_register_interface #(
    parameter int PATH_DEPTH = 64
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire fio_pkg::req_t req_i,
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output fio_pkg::rsp_t rsp_o,
    output logic fs_cmd_valid_o,
    input wire logic fs_cmd_ready_i,
    output fio_pkg::fs_op_t fs_op_o,
    output logic [PATH_DEPTH*8-1:0] fs_path_o,
    output logic [31:0] fs_path_len_o,
    output logic fs_path_abs_o,
    input wire logic fs_name_valid_i,
    input wire logic [7:0] fs_name_byte_i,
    input wire logic fs_done_i,
    input wire fio_pkg::fs_res_t fs_res_i,
    input wire fio_pkg::disk_t disk_i
);
    localparam int IW = $clog2(PATH_DEPTH);
    localparam logic [31:0] DEPTH_W = 32'(PATH_DEPTH);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT = 3'b100
    } state_t;

    state_t state_ff;
    fio_pkg::fs_op_t op_ff;
    fio_pkg::fs_op_t nxt_op;
    logic issue;
    logic take;
    logic push_v;
    fio_pkg::rsp_t push_d;
    logic [7:0] pin_buf_ff [PATH_DEPTH];
    logic [31:0] pin_len_ff;
    logic [31:0] pin_idx_ff;
    logic abs_ff;
    logic [7:0] pout_buf_ff [PATH_DEPTH];
    logic [31:0] pout_len_ff;
    logic [31:0] pout_rd_ff;
    logic [31:0] name_idx_ff;
    logic [15:0] attr_ff;
    logic [31:0] entry_size_ff;
    logic iter_ff;
    logic open_ff;
    logic [31:0] file_size_ff;
    logic [31:0] file_rd_ff;
    fio_pkg::disk_t snap_ff;
    fio_pkg::rsp_t fifo_ff [2];
    logic wp_ff;
    logic rp_ff;
    logic [1:0] cnt_ff;
    logic [31:0] last_idx;
    logic path_ok;
    logic name_op;
    logic done;

    function automatic logic wr(input logic [15:0] a);
        return take && req_i.write && req_i.addr == a;
    endfunction

    function automatic logic rd(input logic [15:0] a);
        return take && !req_i.write && req_i.addr == a;
    endfunction

    assign req_ready_o = state_ff == ST_IDLE && cnt_ff != 2'h2;
    assign take = req_valid_i && req_ready_o;
    assign done = state_ff == ST_WAIT && fs_done_i;
    assign name_op = op_ff == fio_pkg::OP_CWD || op_ff == fio_pkg::OP_FIRST
        || op_ff == fio_pkg::OP_NEXT;
    assign last_idx = pin_len_ff - 32'h1;
    // Length counts the null, all bytes arrived, last one is null
    assign path_ok = pin_len_ff != 32'h0 && pin_len_ff <= DEPTH_W
        && pin_idx_ff == pin_len_ff && pin_buf_ff[last_idx[IW-1:0]] == 8'h0;

    assign fs_cmd_valid_o = state_ff == ST_ISSUE;
    assign fs_op_o = op_ff;
    assign fs_path_len_o = pin_len_ff;
    assign fs_path_abs_o = abs_ff;

    genvar gi;
    generate
        for (gi = 0; gi < PATH_DEPTH; gi++) begin : g_path
            assign fs_path_o[gi*8 +: 8] = pin_buf_ff[gi];
        end
    endgenerate

    always_comb begin
        push_v = 1'b0;
        push_d = '0;
        issue = 1'b0;
        nxt_op = fio_pkg::OP_CWD;
        if (take) begin
            push_v = 1'b1;
            if (wr(fio_pkg::ADDR_PATH_IN_LEN) || wr(fio_pkg::ADDR_PATH_IN_BUF)) begin
                push_d.code = fio_pkg::CODE_OK;
            end else if (rd(fio_pkg::ADDR_PATH_OUT_LEN)) begin
                push_d.rdata = pout_len_ff;
            end else if (rd(fio_pkg::ADDR_PATH_OUT_BUF)) begin
                if (pout_rd_ff < pout_len_ff) begin
                    push_d.rdata = {24'h0, pout_buf_ff[pout_rd_ff[IW-1:0]]};
                end
            end else if (rd(fio_pkg::ADDR_ATTR)) begin
                push_d.rdata = {16'h0, attr_ff};
            end else if (rd(fio_pkg::ADDR_SIZE)) begin
                push_d.rdata = entry_size_ff;
            end else if (rd(fio_pkg::ADDR_SECTOR)) begin
                push_d.rdata = disk_i.sector;
            end else if (rd(fio_pkg::ADDR_CLUSTER_SECT)) begin
                push_d.rdata = snap_ff.cluster_sect;
            end else if (rd(fio_pkg::ADDR_TOTAL)) begin
                push_d.rdata = snap_ff.total;
            end else if (rd(fio_pkg::ADDR_FREE)) begin
                push_d.rdata = snap_ff.free;
            end else if (rd(fio_pkg::ADDR_FORMAT)) begin
                push_d.rdata = {30'h0, disk_i.format};
            end else if (wr(fio_pkg::ADDR_DIR_CURRENT)) begin
                push_v = 1'b0;
                issue = 1'b1;
                nxt_op = fio_pkg::OP_CWD;
            end else if (wr(fio_pkg::ADDR_LIST_FIRST)) begin
                push_v = 1'b0;
                issue = 1'b1;
                nxt_op = fio_pkg::OP_FIRST;
            end else if (wr(fio_pkg::ADDR_LIST_NEXT)) begin
                if (iter_ff) begin
                    push_v = 1'b0;
                    issue = 1'b1;
                    nxt_op = fio_pkg::OP_NEXT;
                end else begin
                    push_d.code = fio_pkg::CODE_BAD_ENTRY;
                end
            end else if (wr(fio_pkg::ADDR_DIR_CHANGE) || wr(fio_pkg::ADDR_OPEN)) begin
                if (path_ok) begin
                    push_v = 1'b0;
                    issue = 1'b1;
                    nxt_op = req_i.addr == fio_pkg::ADDR_OPEN ? fio_pkg::OP_OPEN
                        : fio_pkg::OP_CHDIR;
                end else begin
                    push_d.code = fio_pkg::CODE_NO_PATH;
                end
            end else if (wr(fio_pkg::ADDR_CLOSE)) begin
                if (open_ff) begin
                    push_v = 1'b0;
                    issue = 1'b1;
                    nxt_op = fio_pkg::OP_CLOSE;
                end else begin
                    push_d.code = fio_pkg::CODE_NOT_OPEN;
                end
            end else if (rd(fio_pkg::ADDR_FILE_READ)) begin
                if (!open_ff) begin
                    push_d.code = fio_pkg::CODE_NOT_OPEN;
                end else if (file_rd_ff >= file_size_ff) begin
                    push_d.code = fio_pkg::CODE_UNDERRUN;
                end else begin
                    push_v = 1'b0;
                    issue = 1'b1;
                    nxt_op = fio_pkg::OP_READ;
                end
            end else if (wr(fio_pkg::ADDR_FILE_WRITE) || wr(fio_pkg::ADDR_DIR_MAKE)
                || wr(fio_pkg::ADDR_DIR_REMOVE)) begin
                push_d.code = fio_pkg::CODE_UNIMPL;
            end else begin
                push_d.code = fio_pkg::CODE_BAD_ADDR;
            end
        end else if (done) begin
            push_v = 1'b1;
            push_d.code = fs_res_i.code;
            if (op_ff == fio_pkg::OP_READ) begin
                push_d.rdata = {24'h0, fs_res_i.size[7:0]};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_ff <= ST_IDLE;
            op_ff <= fio_pkg::OP_CWD;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (issue) begin
                        state_ff <= ST_ISSUE;
                        op_ff <= nxt_op;
                    end
                end
                ST_ISSUE: begin
                    if (fs_cmd_ready_i) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (fs_done_i) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Path input buffer, filled one byte per write
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pin_len_ff <= fio_pkg::RESET_WORD;
            pin_idx_ff <= fio_pkg::RESET_WORD;
            abs_ff <= 1'b0;
            for (int i = 0; i < PATH_DEPTH; i++) begin
                pin_buf_ff[i] <= 8'h0;
            end
        end else if (wr(fio_pkg::ADDR_PATH_IN_LEN)) begin
            pin_len_ff <= req_i.wdata;
            pin_idx_ff <= fio_pkg::RESET_WORD;
        end else if (wr(fio_pkg::ADDR_PATH_IN_BUF) && pin_idx_ff < DEPTH_W) begin
            pin_buf_ff[pin_idx_ff[IW-1:0]] <= req_i.wdata[7:0];
            pin_idx_ff <= pin_idx_ff + 32'h1;
            if (pin_idx_ff == 32'h0) begin
                abs_ff <= req_i.wdata[7:0] == fio_pkg::SEPARATOR;
            end
        end
    end

    // Readback buffer: cleared at each name request so the null follows the name
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pout_len_ff <= fio_pkg::RESET_WORD;
            pout_rd_ff <= fio_pkg::RESET_WORD;
            name_idx_ff <= fio_pkg::RESET_WORD;
            for (int i = 0; i < PATH_DEPTH; i++) begin
                pout_buf_ff[i] <= 8'h0;
            end
        end else if (state_ff == ST_ISSUE && name_op) begin
            name_idx_ff <= fio_pkg::RESET_WORD;
            pout_len_ff <= fio_pkg::RESET_WORD;
            pout_rd_ff <= fio_pkg::RESET_WORD;
            for (int i = 0; i < PATH_DEPTH; i++) begin
                pout_buf_ff[i] <= 8'h0;
            end
        end else if (state_ff == ST_WAIT && name_op) begin
            if (fs_name_valid_i && name_idx_ff < DEPTH_W - 32'h1) begin
                pout_buf_ff[name_idx_ff[IW-1:0]] <= fs_name_byte_i;
                name_idx_ff <= name_idx_ff + 32'h1;
            end
            if (fs_done_i && fs_res_i.code == fio_pkg::CODE_OK) begin
                if (op_ff == fio_pkg::OP_CWD && name_idx_ff == 32'h0) begin
                    pout_buf_ff[0] <= fio_pkg::SEPARATOR;
                    pout_len_ff <= fio_pkg::ROOT_LEN;
                end else begin
                    pout_len_ff <= name_idx_ff + 32'h1;
                end
            end
        end else if (rd(fio_pkg::ADDR_PATH_OUT_BUF) && pout_rd_ff < DEPTH_W) begin
            pout_rd_ff <= pout_rd_ff + 32'h1;
        end
    end

    // Entry attributes, iteration and open-file state
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            attr_ff <= 16'h0;
            entry_size_ff <= fio_pkg::RESET_WORD;
            iter_ff <= 1'b0;
            open_ff <= 1'b0;
            file_size_ff <= fio_pkg::RESET_WORD;
            file_rd_ff <= fio_pkg::RESET_WORD;
        end else if (done) begin
            if (op_ff == fio_pkg::OP_FIRST || op_ff == fio_pkg::OP_NEXT) begin
                iter_ff <= fs_res_i.code == fio_pkg::CODE_OK;
                if (fs_res_i.code == fio_pkg::CODE_OK) begin
                    attr_ff <= 16'h0;
                    attr_ff[fio_pkg::ATTR_DIR_BIT] <= fs_res_i.is_dir;
                    attr_ff[fio_pkg::ATTR_FILE_BIT] <= !fs_res_i.is_dir;
                    entry_size_ff <= fs_res_i.is_dir ? 32'h0 : fs_res_i.size;
                end
            end
            if (op_ff == fio_pkg::OP_CHDIR && fs_res_i.code == fio_pkg::CODE_OK) begin
                iter_ff <= 1'b0;
            end
            if (op_ff == fio_pkg::OP_OPEN && fs_res_i.code == fio_pkg::CODE_OK) begin
                open_ff <= 1'b1;
                file_size_ff <= fs_res_i.size;
                file_rd_ff <= fio_pkg::RESET_WORD;
            end
            if (op_ff == fio_pkg::OP_CLOSE) begin
                open_ff <= 1'b0;
            end
            if (op_ff == fio_pkg::OP_READ) begin
                file_rd_ff <= file_rd_ff + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            snap_ff <= '0;
        end else if (rd(fio_pkg::ADDR_SECTOR)) begin
            snap_ff <= disk_i;
        end
    end

    // Two-entry answer buffer
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
            fifo_ff[0] <= '0;
            fifo_ff[1] <= '0;
        end else begin
            if (push_v) begin
                fifo_ff[wp_ff] <= push_d;
                wp_ff <= !wp_ff;
            end
            if (rsp_valid_o && rsp_ready_i) begin
                rp_ff <= !rp_ff;
            end
            cnt_ff <= cnt_ff + 2'(push_v) - 2'(rsp_valid_o && rsp_ready_i);
        end
    end

    assign rsp_valid_o = cnt_ff != 2'h0;
    assign rsp_o = fifo_ff[rp_ff];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_ZERO_FILL: assert property (
        take && !req_i.write && req_i.addr == fio_pkg::ADDR_PATH_OUT_BUF
        && pout_rd_ff >= pout_len_ff |-> push_v && push_d.rdata == 32'h0)
        else $error("readback beyond length not zero");
    AST_ROOT_SLASH: assert property (
        done && op_ff == fio_pkg::OP_CWD && fs_res_i.code == 16'h0 && name_idx_ff == 32'h0
        |=> pout_buf_ff[0] == 8'h2f && pout_len_ff == 32'h2 && rsp_valid_o)
        else $error("root not reported as slash");
    AST_DIR_ATTR: assert property (
        done && op_ff == fio_pkg::OP_FIRST && fs_res_i.code == 16'h0 && fs_res_i.is_dir
        |=> attr_ff == 16'h0010 && entry_size_ff == 32'h0)
        else $error("directory attribute wrong");
    AST_NEXT_IDLE: assert property (
        take && req_i.write && req_i.addr == fio_pkg::ADDR_LIST_NEXT && !iter_ff
        |-> push_v && push_d.code == 16'h0af9)
        else $error("next without iteration not refused");
    AST_SNAPSHOT: assert property (
        take && !req_i.write && req_i.addr == fio_pkg::ADDR_SECTOR
        |=> snap_ff.free == $past(disk_i.free)
        && snap_ff.total == $past(disk_i.total))
        else $error("disk snapshot not taken");
    AST_UNDERRUN: assert property (
        take && !req_i.write && req_i.addr == fio_pkg::ADDR_FILE_READ && open_ff
        && file_rd_ff >= file_size_ff
        |-> push_d.code == 16'h0f04 ##1 state_ff == ST_IDLE)
        else $error("file underrun not reported");
    AST_NO_PATH: assert property (
        take && req_i.write && req_i.addr == fio_pkg::ADDR_OPEN && !path_ok
        |-> push_v && push_d.code == 16'h0f02)
        else $error("open without path accepted");
    AST_UNIMPL: assert property (
        take && req_i.write && req_i.addr == fio_pkg::ADDR_FILE_WRITE
        |-> push_d.code == 16'h0f01 ##1 state_ff == ST_IDLE)
        else $error("file write not refused");
    AST_FIRST_ISSUE: assert property (
        take && req_i.write && req_i.addr == fio_pkg::ADDR_LIST_FIRST
        |=> fs_cmd_valid_o && fs_op_o == fio_pkg::OP_FIRST)
        else $error("list first not issued");
endmodule // file_access_register_interface
`default_nettype wire

/* common/fio_pkg.sv */
`default_nettype none
package fio_pkg;
    // Register addresses (16-bit register numbers)
    localparam logic [15:0] ADDR_DIR_CHANGE = 16'hecb8;
    localparam logic [15:0] ADDR_DIR_CURRENT = 16'hecb9;
    localparam logic [15:0] ADDR_DIR_MAKE = 16'hecba;
    localparam logic [15:0] ADDR_DIR_REMOVE = 16'hecbb;
    localparam logic [15:0] ADDR_LIST_FIRST = 16'hecc2;
    localparam logic [15:0] ADDR_LIST_NEXT = 16'hecc3;
    localparam logic [15:0] ADDR_OPEN = 16'heccc;
    localparam logic [15:0] ADDR_CLOSE = 16'heccd;
    localparam logic [15:0] ADDR_ATTR = 16'heccf;
    localparam logic [15:0] ADDR_SIZE = 16'hecd4;
    localparam logic [15:0] ADDR_SECTOR = 16'hecd6;
    localparam logic [15:0] ADDR_CLUSTER_SECT = 16'hecd8;
    localparam logic [15:0] ADDR_TOTAL = 16'hecda;
    localparam logic [15:0] ADDR_FREE = 16'hecdc;
    localparam logic [15:0] ADDR_FORMAT = 16'hecde;
    localparam logic [15:0] ADDR_PATH_IN_LEN = 16'hece0;
    localparam logic [15:0] ADDR_PATH_OUT_LEN = 16'hece2;
    localparam logic [15:0] ADDR_PATH_IN_BUF = 16'hecea;
    localparam logic [15:0] ADDR_PATH_OUT_BUF = 16'hecec;
    localparam logic [15:0] ADDR_FILE_WRITE = 16'hecee;
    localparam logic [15:0] ADDR_FILE_READ = 16'hecf0;
    // Result codes
    localparam logic [15:0] CODE_OK = 16'h0000;
    localparam logic [15:0] CODE_NOT_FOUND = 16'h0b90;
    localparam logic [15:0] CODE_LISTING_EXHAUSTED = 16'h0b96;
    localparam logic [15:0] CODE_BAD_ENTRY = 16'h0af9;
    localparam logic [15:0] CODE_UNIMPL = 16'h0f01;
    localparam logic [15:0] CODE_NO_PATH = 16'h0f02;
    localparam logic [15:0] CODE_NOT_OPEN = 16'h0f03;
    localparam logic [15:0] CODE_UNDERRUN = 16'h0f04;
    localparam logic [15:0] CODE_BAD_ADDR = 16'h0f05;
    // Attribute bits, separator, readback length of the root
    localparam int ATTR_DIR_BIT = 4;
    localparam int ATTR_FILE_BIT = 5;
    localparam logic [7:0] SEPARATOR = 8'h2f;
    localparam logic [31:0] ROOT_LEN = 32'h2;
    localparam logic [31:0] RESET_WORD = 32'h0;

    typedef enum logic [6:0] {
        OP_CWD = 7'b0000001,
        OP_FIRST = 7'b0000010,
        OP_NEXT = 7'b0000100,
        OP_CHDIR = 7'b0001000,
        OP_OPEN = 7'b0010000,
        OP_CLOSE = 7'b0100000,
        OP_READ = 7'b1000000
    } fs_op_t;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic [15:0] code;
    } rsp_t;

    typedef struct packed {
        logic [15:0] code;
        logic is_dir;
        logic [31:0] size;
    } fs_res_t;

    // Format: 0 none/unknown, 1 FAT12, 2 FAT16, 3 FAT32
    typedef struct packed {
        logic [31:0] sector;
        logic [31:0] cluster_sect;
        logic [31:0] total;
        logic [31:0] free;
        logic [1:0] format;
    } disk_t;
endpackage
`default_nettype wire

/* test/fs_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fs_engine_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    input wire logic fs_cmd_valid_i,
    input wire fio_pkg::fs_op_t fs_op_i,
    output logic fs_cmd_ready_o,
    output logic fs_name_valid_o,
    output logic [7:0] fs_name_byte_o,
    output logic fs_done_o,
    output fio_pkg::fs_res_t fs_res_o
);
    logic in_sub = 1'b0;
    int step = 0;
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            fs_name_valid_o <= 1'b1;
            fs_name_byte_o <= s[i];
            @(posedge clk_sys_i);
        end
        fs_name_valid_o <= 1'b0;
    endtask
    task automatic done(input logic [15:0] code, input logic dir, input logic [31:0] size);
        fs_done_o <= 1'b1;
        fs_res_o <= '{code, dir, size};
        @(posedge clk_sys_i);
        fs_done_o <= 1'b0;
        fs_res_o <= ~fs_res_o;
    endtask
    initial begin
        fs_cmd_ready_o = 1'b0;
        fs_name_valid_o = 1'b0;
        fs_name_byte_o = 8'h00;
        fs_done_o = 1'b0;
        fs_res_o = '0;
        forever begin
            @(posedge clk_sys_i);
            // Idle name lines keep moving so a stale byte is never mistaken for data
            fs_name_byte_o <= ~fs_name_byte_o;
            if (fs_cmd_valid_i) begin
                if (slow_i) repeat (5) @(posedge clk_sys_i);
                fs_cmd_ready_o <= 1'b1;
                @(posedge clk_sys_i);
                fs_cmd_ready_o <= 1'b0;
                case (fs_op_i)
                    fio_pkg::OP_CWD: begin
                        if (in_sub) send("/D");
                        done(fio_pkg::CODE_OK, 1'b0, 32'h0);
                    end
                    fio_pkg::OP_FIRST: begin
                        step = 0;
                        if (in_sub) done(fio_pkg::CODE_NOT_FOUND, 1'b0, 32'h0);
                        else begin
                            send("D");
                            done(fio_pkg::CODE_OK, 1'b1, 32'h0);
                        end
                    end
                    fio_pkg::OP_NEXT: begin
                        step++;
                        if (step == 1) begin
                            send("F");
                            done(fio_pkg::CODE_OK, 1'b0, 32'h5);
                        end else done(fio_pkg::CODE_LISTING_EXHAUSTED, 1'b0, 32'h0);
                    end
                    fio_pkg::OP_CHDIR: begin
                        in_sub = 1'b1;
                        done(fio_pkg::CODE_OK, 1'b0, 32'h0);
                    end
                    fio_pkg::OP_OPEN: done(fio_pkg::CODE_OK, 1'b0, 32'h2);
                    fio_pkg::OP_READ: done(fio_pkg::CODE_OK, 1'b0, 32'h5a);
                    default: done(fio_pkg::CODE_OK, 1'b0, 32'h0);
                endcase
            end
        end
    end
endmodule // fs_engine_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic rsp_ready_i = 1'b1;
    logic slow_i = 1'b0;
    fio_pkg::req_t req_i = '0;
    fio_pkg::disk_t disk_i = '0;
    logic req_ready_o, rsp_valid_o, fs_cmd_valid_o, fs_cmd_ready_i, fs_name_valid_i;
    logic fs_done_i, fs_path_abs_o;
    logic [7:0] fs_name_byte_i;
    logic [31:0] fs_path_len_o, rdata;
    logic [511:0] fs_path_o;
    logic [15:0] rcode;
    fio_pkg::rsp_t rsp_o;
    fio_pkg::fs_op_t fs_op_o;
    fio_pkg::fs_res_t fs_res_i;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    always #12.5 clk_sys_i = ~clk_sys_i;
    file_access_register_interface u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
        .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_o(rsp_o),
        .fs_cmd_valid_o(fs_cmd_valid_o), .fs_cmd_ready_i(fs_cmd_ready_i), .fs_op_o(fs_op_o),
        .fs_path_o(fs_path_o), .fs_path_len_o(fs_path_len_o), .fs_path_abs_o(fs_path_abs_o),
        .fs_name_valid_i(fs_name_valid_i), .fs_name_byte_i(fs_name_byte_i),
        .fs_done_i(fs_done_i), .fs_res_i(fs_res_i), .disk_i(disk_i));
    fs_engine_model u_engine (.clk_sys_i(clk_sys_i), .slow_i(slow_i),
        .fs_cmd_valid_i(fs_cmd_valid_o), .fs_op_i(fs_op_o), .fs_cmd_ready_o(fs_cmd_ready_i),
        .fs_name_valid_o(fs_name_valid_i), .fs_name_byte_o(fs_name_byte_i),
        .fs_done_o(fs_done_i), .fs_res_o(fs_res_i));
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d);
        req_i <= '{wr, a, d};
        req_valid_i <= 1'b1;
        do @(posedge clk_sys_i); while (!req_ready_o);
        req_valid_i <= 1'b0;
        do @(posedge clk_sys_i); while (!rsp_valid_o);
        rdata = rsp_o.rdata;
        rcode = rsp_o.code;
    endtask
    task automatic cmd(input logic [15:0] a, input logic [15:0] exp, input string what);
        access(1'b1, a, 32'h1);
        check(what, {16'h0, exp}, {16'h0, rcode});
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
        access(1'b0, a, 32'h0);
        check(what, exp, rdata);
    endtask
    task automatic put_path(input string s);
        access(1'b1, fio_pkg::ADDR_PATH_IN_LEN, 32'(s.len() + 1));
        for (int i = 0; i <= s.len(); i++)
            access(1'b1, fio_pkg::ADDR_PATH_IN_BUF, (i < s.len()) ? 32'(s[i]) : 32'h0);
    endtask
    task automatic t_cwd_list();
        cmd(fio_pkg::ADDR_DIR_CURRENT, fio_pkg::CODE_OK, "cwd code");
        rd(fio_pkg::ADDR_PATH_OUT_LEN, fio_pkg::ROOT_LEN, "cwd length");
        rd(fio_pkg::ADDR_PATH_OUT_BUF, {24'h0, fio_pkg::SEPARATOR}, "cwd byte");
        rd(fio_pkg::ADDR_PATH_OUT_BUF, 32'h0, "cwd null");
        rd(fio_pkg::ADDR_PATH_OUT_BUF, 32'h0, "cwd underrun");
        cmd(fio_pkg::ADDR_LIST_FIRST, fio_pkg::CODE_OK, "first code");
        rd(fio_pkg::ADDR_ATTR, 32'h10, "first attr");
        rd(fio_pkg::ADDR_SIZE, 32'h0, "first size");
        rd(fio_pkg::ADDR_PATH_OUT_LEN, 32'h2, "first name length");
        rd(fio_pkg::ADDR_PATH_OUT_BUF, 32'h44, "first name");
        cmd(fio_pkg::ADDR_LIST_NEXT, fio_pkg::CODE_OK, "next code");
        rd(fio_pkg::ADDR_ATTR, 32'h20, "next attr");
        rd(fio_pkg::ADDR_SIZE, 32'h5, "next size");
        cmd(fio_pkg::ADDR_LIST_NEXT, fio_pkg::CODE_LISTING_EXHAUSTED, "next end");
        cmd(fio_pkg::ADDR_LIST_NEXT, fio_pkg::CODE_BAD_ENTRY, "next idle");
        $display("test cwd and listing done");
    endtask
    task automatic t_chdir();
        slow_i <= 1'b1;
        put_path("D");
        check("path abs", 32'h0, {31'h0, fs_path_abs_o});
        cmd(fio_pkg::ADDR_DIR_CHANGE, fio_pkg::CODE_OK, "chdir code");
        cmd(fio_pkg::ADDR_LIST_FIRST, fio_pkg::CODE_NOT_FOUND, "empty first");
        cmd(fio_pkg::ADDR_DIR_CURRENT, fio_pkg::CODE_OK, "sub cwd code");
        rd(fio_pkg::ADDR_PATH_OUT_LEN, 32'h3, "sub cwd length");
        slow_i <= 1'b0;
        $display("test chdir done");
    endtask
    task automatic t_file();
        access(1'b1, fio_pkg::ADDR_PATH_IN_LEN, 32'h3);
        access(1'b1, fio_pkg::ADDR_PATH_IN_BUF, 32'h2f);
        cmd(fio_pkg::ADDR_OPEN, fio_pkg::CODE_NO_PATH, "open short path");
        cmd(fio_pkg::ADDR_DIR_CHANGE, fio_pkg::CODE_NO_PATH, "chdir short path");
        put_path("/F");
        check("path length", 32'h3, fs_path_len_o);
        check("path abs", 32'h1, {31'h0, fs_path_abs_o});
        check("path bytes", 32'h0000462f, {8'h0, fs_path_o[23:0]});
        cmd(fio_pkg::ADDR_OPEN, fio_pkg::CODE_OK, "open code");
        rd(fio_pkg::ADDR_FILE_READ, 32'h5a, "file byte 0");
        rd(fio_pkg::ADDR_FILE_READ, 32'h5a, "file byte 1");
        access(1'b0, fio_pkg::ADDR_FILE_READ, 32'h0);
        check("read past end", {16'h0, fio_pkg::CODE_UNDERRUN}, {16'h0, rcode});
        cmd(fio_pkg::ADDR_CLOSE, fio_pkg::CODE_OK, "close code");
        cmd(fio_pkg::ADDR_CLOSE, fio_pkg::CODE_NOT_OPEN, "close again");
        access(1'b0, fio_pkg::ADDR_FILE_READ, 32'h0);
        check("read closed", {16'h0, fio_pkg::CODE_NOT_OPEN}, {16'h0, rcode});
        cmd(fio_pkg::ADDR_FILE_WRITE, fio_pkg::CODE_UNIMPL, "file write");
        cmd(fio_pkg::ADDR_DIR_MAKE, fio_pkg::CODE_UNIMPL, "dir make");
        cmd(fio_pkg::ADDR_DIR_REMOVE, fio_pkg::CODE_UNIMPL, "dir remove");
        cmd(16'h0000, fio_pkg::CODE_BAD_ADDR, "unmapped");
        access(1'b0, fio_pkg::ADDR_LIST_FIRST, 32'h0);
        check("trigger read", {16'h0, fio_pkg::CODE_BAD_ADDR}, {16'h0, rcode});
        $display("test file done");
    endtask
    task automatic t_disk_stall();
        disk_i <= '{32'h200, 32'h40, 32'h1e00, 32'h0f00, 2'h3};
        @(posedge clk_sys_i);
        rd(fio_pkg::ADDR_SECTOR, 32'h200, "sector size");
        disk_i <= '{32'h400, 32'h8, 32'h1, 32'h2, 2'h2};
        rd(fio_pkg::ADDR_CLUSTER_SECT, 32'h40, "cluster sectors");
        rd(fio_pkg::ADDR_TOTAL, 32'h1e00, "total clusters");
        rd(fio_pkg::ADDR_FREE, 32'h0f00, "free clusters");
        rd(fio_pkg::ADDR_FORMAT, 32'h2, "format");
        // Receiver stalls: only two answers fit, the rest must wait
        rsp_ready_i <= 1'b0;
        req_i <= '{1'b1, fio_pkg::ADDR_PATH_IN_LEN, 32'h1};
        req_valid_i <= 1'b1;
        n = 0;
        repeat (12) begin
            @(posedge clk_sys_i);
            if (req_ready_o && req_valid_i) n++;
            if (n == 2) req_valid_i <= 1'b0;
        end
        check("taken while stalled", 32'h2, 32'(n));
        rsp_ready_i <= 1'b1;
        n = 0;
        repeat (6) begin
            @(posedge clk_sys_i);
            if (rsp_valid_o && rsp_ready_i) n++;
        end
        check("answers drained", 32'h2, 32'(n));
        $display("test disk and stall done");
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_cwd_list();
        t_chdir();
        t_file();
        t_disk_stall();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
